// file: hw/twwc_defs.svh
/*
 * constants for the two-wire wiper control block: command codes, byte
 * positions, timing and reset values.
 * assumes it is included by its bare name wherever the constants are used.
 */
`ifndef TWWC_DEFS_SVH
`define TWWC_DEFS_SVH

// {opcode[2:0], read/write bit}
`define TWWC_OP_RD_WIPER 4'h9
`define TWWC_OP_WR_WIPER 4'ha
`define TWWC_OP_RD_SLOT 4'hb
`define TWWC_OP_WR_SLOT 4'hc
`define TWWC_OP_XFR_S2W 4'hd
`define TWWC_OP_XFR_W2S 4'he

// byte position inside one transaction, and index of the last bit in a byte
`define TWWC_IDX_ADDR 3'h0
`define TWWC_IDX_CMD 3'h1
`define TWWC_IDX_LO 3'h2
`define TWWC_IDX_HI 3'h3
`define TWWC_BIT_LAST 3'h7

// fixed upper five address bits; value is arbitrary
`define TWWC_TYPE_CODE 5'h14
// contents of the saved slots after reset
`define TWWC_SLOT_RESET 10'h200

// nonvolatile write cycle and core clock period
`define TWWC_TWC_NS 5000000
`define TWWC_CLK_NS 10

`endif

// file: hw/twwc_pkg.sv
/*
 * types for the two-wire wiper control block.
 * assumes nothing of its surroundings.
 */
package twwc_pkg;

  typedef enum logic [8:0] {
    TWWC_INIT = 9'h001,
    TWWC_IDLE = 9'h002,
    TWWC_RX = 9'h004,
    TWWC_ACK1 = 9'h008,
    TWWC_ACK2 = 9'h010,
    TWWC_TX = 9'h020,
    TWWC_MREL = 9'h040,
    TWWC_MSMP = 9'h080,
    TWWC_IGN = 9'h100
  } twwc_state_e;

  // decoded command: opcode with read/write bit, and slot pointer
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] slot;
  } twwc_cmd_s;

endpackage

// file: hw/twwc_core.sv
/*
 * two-wire bus slave holding the wiper position register, four saved
 * setting slots and the one-of-1024 tap decode.
 * assumes the bus master drives scl_in, the board pulls sda up, and
 * clock_in runs well above the serial clock rate.
 */
// What this block does
// - sample incoming bits at serial clock rise, change output after fall.
// - data line is open drain: pull low or release only.
// - low two address bits equal the strap pins, upper bits fixed code.
// - only a matching address is answered; others are ignored.
// - write protect low blocks every nonvolatile slot write.
// - at power-up load slot zero into the wiper register first.
// - 10-bit wiper register alone selects one of 1024 taps.
// - one wiper register and four slots, all readable and writable.
// - support register write, register read, and wiper/slot transfers.
// - command byte holds opcode, zero, two-bit slot select, two zeros.
// - six opcode and read/write pairs select the six operations.
// - acknowledge address, command byte and each data byte.
// - after a stop ends a slot write, refuse address ack about 5 ms.
`include "twwc_defs.svh"

module twwc_core #(
  parameter int NV_WRITE_CYCLES = `TWWC_TWC_NS / `TWWC_CLK_NS
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] address_strap_pins_in,
  input wire logic write_protect_n_in,
  output logic [9:0] wiper_position_out,
  output logic [1023:0] tap_select_out,
  output logic busy_out
);
  localparam int BW = $clog2(NV_WRITE_CYCLES + 1);
  localparam logic [BW-1:0] BUSY_LOAD = BW'(NV_WRITE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [2:0] scl_sync_reg, sda_sync_reg, tgl_sync_reg;
  logic [1:0] wp_sync_reg;
  logic [1:0] strap_sync_reg [2];
  logic rise_bit_reg, rise_tgl_reg;

  assign rst_n = rst_sync_reg[1];

  // reset is asserted at once but released through two flops
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // bit 0 is the metastable stage, bit 2 is only the edge history
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      tgl_sync_reg <= 3'h0;
      wp_sync_reg <= 2'h0;
      strap_sync_reg[0] <= 2'h0;
      strap_sync_reg[1] <= 2'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      tgl_sync_reg <= {tgl_sync_reg[1:0], rise_tgl_reg};
      wp_sync_reg <= {wp_sync_reg[0], write_protect_n_in};
      strap_sync_reg[0] <= address_strap_pins_in;
      strap_sync_reg[1] <= strap_sync_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock domain: bits are captured on the master's own rising edge

  always_ff @(posedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      rise_bit_reg <= 1'b1;
      rise_tgl_reg <= 1'b0;
    end else begin
      rise_bit_reg <= sda_in;
      rise_tgl_reg <= ~rise_tgl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus events; the captured bit is stable for a whole serial period, so
  // reading it once the toggle has crossed is safe
  logic rise_ev, fall_ev, start_ev, stop_ev, bit_in;
  logic [7:0] shift_reg, shift_next, lo_reg, lo_next;
  logic [7:0] byte_in;

  assign rise_ev = tgl_sync_reg[2] ^ tgl_sync_reg[1];
  assign fall_ev = scl_sync_reg[2] & ~scl_sync_reg[1];
  assign start_ev = scl_sync_reg[1] & sda_sync_reg[2] & ~sda_sync_reg[1];
  assign stop_ev = scl_sync_reg[1] & ~sda_sync_reg[2] & sda_sync_reg[1];
  assign bit_in = rise_bit_reg;
  assign byte_in = {shift_reg[6:0], bit_in};

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine, registers and nonvolatile slots
  twwc_pkg::twwc_state_e state_reg, state_next;
  twwc_pkg::twwc_cmd_s cmd_reg, cmd_next;
  logic [2:0] cnt_reg, cnt_next, idx_reg, idx_next;
  logic oe_reg, oe_next, rw_reg, rw_next, pend_reg, pend_next;
  logic [9:0] wiper_reg, wiper_next, nv_val_reg, nv_val_next, src;
  logic [9:0] slots_reg [4];
  logic [9:0] slots_next [4];
  logic [BW-1:0] busy_reg, busy_next;
  logic [1023:0] tap_reg, tap_next;
  logic [7:0] tx_byte;
  logic ok, is_read, is_write;

  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    shift_next = shift_reg;
    lo_next = lo_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    pend_next = pend_reg;
    wiper_next = wiper_reg;
    nv_val_next = nv_val_reg;
    slots_next = slots_reg;
    busy_next = (busy_reg != '0) ? busy_reg - BW'(1) : busy_reg;
    ok = 1'b0;
    is_read = (cmd_reg.op == `TWWC_OP_RD_WIPER) || (cmd_reg.op == `TWWC_OP_RD_SLOT);
    is_write = (cmd_reg.op == `TWWC_OP_WR_WIPER) || (cmd_reg.op == `TWWC_OP_WR_SLOT);
    src = (cmd_reg.op == `TWWC_OP_RD_WIPER) ? wiper_reg : slots_reg[cmd_reg.slot];
    tx_byte = (idx_reg == `TWWC_IDX_LO) ? src[7:0] : {6'h00, src[9:8]};
    if (state_reg == twwc_pkg::TWWC_INIT) begin
      wiper_next = slots_reg[0];
      state_next = twwc_pkg::TWWC_IDLE;
    end else if (start_ev) begin
      state_next = twwc_pkg::TWWC_RX;
      cnt_next = 3'h0;
      idx_next = `TWWC_IDX_ADDR;
      oe_next = 1'b0;
      pend_next = 1'b0;
    end else if (stop_ev) begin
      state_next = twwc_pkg::TWWC_IDLE;
      oe_next = 1'b0;
      pend_next = 1'b0;
      if (pend_reg && wp_sync_reg[1]) begin
        slots_next[cmd_reg.slot] = nv_val_reg;
        busy_next = BUSY_LOAD;
      end
    end else begin
      case (state_reg)
        twwc_pkg::TWWC_RX: begin
          if (rise_ev) begin
            shift_next = byte_in;
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == `TWWC_BIT_LAST) begin
              case (idx_reg)
                `TWWC_IDX_ADDR: begin
                  ok = (byte_in[7:3] == `TWWC_TYPE_CODE) &&
                       (byte_in[2:1] == strap_sync_reg[1]) && (busy_reg == '0);
                  rw_next = byte_in[0];
                end
                `TWWC_IDX_CMD: begin
                  cmd_next.op = {byte_in[7:5], rw_reg};
                  cmd_next.slot = byte_in[3:2];
                  ok = 1'b1;
                  case ({byte_in[7:5], rw_reg})
                    `TWWC_OP_XFR_S2W: wiper_next = slots_reg[byte_in[3:2]];
                    `TWWC_OP_XFR_W2S: begin
                      pend_next = 1'b1;
                      nv_val_next = wiper_reg;
                    end
                    `TWWC_OP_RD_WIPER, `TWWC_OP_WR_WIPER, `TWWC_OP_RD_SLOT,
                    `TWWC_OP_WR_SLOT: ok = 1'b1;
                    default: ok = 1'b0;
                  endcase
                end
                `TWWC_IDX_LO: begin
                  ok = is_write;
                  lo_next = byte_in;
                end
                `TWWC_IDX_HI: begin
                  ok = is_write;
                  if (cmd_reg.op == `TWWC_OP_WR_WIPER) begin
                    wiper_next = {byte_in[1:0], lo_reg};
                  end else begin
                    pend_next = 1'b1;
                    nv_val_next = {byte_in[1:0], lo_reg};
                  end
                end
                default: ok = 1'b0;
              endcase
              idx_next = idx_reg + 3'h1;
              state_next = ok ? twwc_pkg::TWWC_ACK1 : twwc_pkg::TWWC_IGN;
            end
          end
        end
        twwc_pkg::TWWC_ACK1: begin
          if (fall_ev) begin
            oe_next = 1'b1;
            state_next = twwc_pkg::TWWC_ACK2;
          end
        end
        twwc_pkg::TWWC_ACK2: begin
          if (fall_ev) begin
            cnt_next = 3'h0;
            if (rw_reg && is_read && idx_reg >= `TWWC_IDX_LO) begin
              oe_next = ~tx_byte[7];
              shift_next = {tx_byte[6:0], 1'b0};
              state_next = twwc_pkg::TWWC_TX;
            end else begin
              oe_next = 1'b0;
              state_next = twwc_pkg::TWWC_RX;
            end
          end
        end
        twwc_pkg::TWWC_TX: begin
          if (fall_ev) begin
            oe_next = ~shift_reg[7];
            shift_next = {shift_reg[6:0], 1'b0};
          end else if (rise_ev) begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == `TWWC_BIT_LAST) begin
              state_next = twwc_pkg::TWWC_MREL;
            end
          end
        end
        twwc_pkg::TWWC_MREL: begin
          if (fall_ev) begin
            oe_next = 1'b0;
            state_next = twwc_pkg::TWWC_MSMP;
          end
        end
        twwc_pkg::TWWC_MSMP: begin
          // master ack on the low byte asks for the high byte
          if (rise_ev) begin
            if (!bit_in && idx_reg == `TWWC_IDX_LO) begin
              idx_next = `TWWC_IDX_HI;
              state_next = twwc_pkg::TWWC_ACK2;
            end else begin
              state_next = twwc_pkg::TWWC_IGN;
            end
          end
        end
        twwc_pkg::TWWC_IDLE, twwc_pkg::TWWC_IGN: state_next = state_reg;
        default: state_next = twwc_pkg::TWWC_IDLE;
      endcase
    end
    tap_next = '0;
    tap_next[wiper_reg] = 1'b1;
  end

  // slots reset to a constant: no real nonvolatile storage here
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= twwc_pkg::TWWC_INIT;
      cmd_reg <= '0;
      cnt_reg <= 3'h0;
      idx_reg <= 3'h0;
      shift_reg <= 8'h00;
      lo_reg <= 8'h00;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      pend_reg <= 1'b0;
      wiper_reg <= 10'h000;
      nv_val_reg <= 10'h000;
      slots_reg <= '{default: `TWWC_SLOT_RESET};
      busy_reg <= '0;
      tap_reg <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      shift_reg <= shift_next;
      lo_reg <= lo_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      pend_reg <= pend_next;
      wiper_reg <= wiper_next;
      nv_val_reg <= nv_val_next;
      slots_reg <= slots_next;
      busy_reg <= busy_next;
      tap_reg <= tap_next;
    end
  end

  // open drain: data is always low, only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_reg;
  assign wiper_position_out = wiper_reg;
  assign tap_select_out = tap_reg;
  assign busy_out = (busy_reg != '0);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic addr_done;
  assign addr_done = (state_reg == twwc_pkg::TWWC_RX) && rise_ev && !start_ev && !stop_ev &&
                     (cnt_reg == `TWWC_BIT_LAST) && (idx_reg == `TWWC_IDX_ADDR);

  property p_oe_on_fall;
    @(posedge clock_in) disable iff (!rst_n)
    $changed(oe_reg) |-> $past(fall_ev) || $past(start_ev) || $past(stop_ev);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("sda moved off a fall");

  property p_released;
    @(posedge clock_in) disable iff (!rst_n)
    sda_oe_out |-> state_reg inside {twwc_pkg::TWWC_ACK2, twwc_pkg::TWWC_TX,
                                     twwc_pkg::TWWC_MREL};
  endproperty
  a_released: assert property (p_released) else $error("sda driven outside ack or tx");

  property p_strap_miss;
    @(posedge clock_in) disable iff (!rst_n)
    addr_done && (byte_in[2:1] != strap_sync_reg[1]) |=> state_reg == twwc_pkg::TWWC_IGN;
  endproperty
  a_strap_miss: assert property (p_strap_miss) else $error("foreign address taken");

  property p_busy_nack;
    @(posedge clock_in) disable iff (!rst_n)
    addr_done && busy_out |=> state_reg == twwc_pkg::TWWC_IGN ##1 !sda_oe_out;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

  property p_busy_start;
    @(posedge clock_in) disable iff (!rst_n)
    stop_ev && pend_reg && wp_sync_reg[1] && state_reg != twwc_pkg::TWWC_INIT
      |=> busy_reg == BUSY_LOAD;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("write cycle not started");

  property p_wp_block;
    @(posedge clock_in) disable iff (!rst_n)
    // a stop may end a poll while an earlier cycle still counts down: only a reload is wrong
    stop_ev && !wp_sync_reg[1] |=> busy_reg != BUSY_LOAD &&
      slots_reg[0] == $past(slots_reg[0]) && slots_reg[1] == $past(slots_reg[1]) &&
      slots_reg[2] == $past(slots_reg[2]) && slots_reg[3] == $past(slots_reg[3]);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("slot written under protect");

  property p_init_load;
    @(posedge clock_in) disable iff (!rst_n)
    state_reg == twwc_pkg::TWWC_INIT |=> wiper_reg == slots_reg[0] ##1 tap_reg[wiper_reg];
  endproperty
  a_init_load: assert property (p_init_load) else $error("slot zero not recalled");

  property p_tap_onehot;
    @(posedge clock_in) disable iff (!rst_n)
    $past(state_reg) != twwc_pkg::TWWC_INIT |-> $onehot(tap_reg) && tap_reg[$past(wiper_reg)];
  endproperty
  a_tap_onehot: assert property (p_tap_onehot) else $error("tap select wrong");

  c_ack: cover property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == twwc_pkg::TWWC_ACK2 && idx_reg == `TWWC_IDX_CMD);
  c_tx: cover property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == twwc_pkg::TWWC_MSMP && idx_reg == `TWWC_IDX_HI);
  c_nvw: cover property (@(posedge clock_in) disable iff (!rst_n) $rose(busy_out));
  c_ign: cover property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == twwc_pkg::TWWC_IGN);

endmodule

// file: verif/twwc_master_model.sv
/*
 * behavioural 2-wire bus master that drives the serial clock and the data line.
 * assumes a board pull-up resolves the data line and a 100 MHz clock paces it.
 */
module twwc_master_model (
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // serial clock edges sit 3.3 ns after a core clock fall, clear of both core clock edges
  localparam realtime SCL_SKEW = 3.3;

  // idle: clock parked high, data released
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // data moves 2 cycles after the fall so it is never mistaken for start or stop
  task automatic bit_xfer(input logic b, output logic r);
    w(2);
    sda_pull_out = ~b;
    w(6);
    scl_out <= #SCL_SKEW 1'b1;
    w(4);
    r = sda_in;
    w(4);
    scl_out <= #SCL_SKEW 1'b0;
  endtask

  task automatic start();
    sda_pull_out = 1'b0;
    w(8);
    sda_pull_out = 1'b1;
    w(8);
    scl_out <= #SCL_SKEW 1'b0;
  endtask

  task automatic stop();
    w(2);
    sda_pull_out = 1'b1;
    w(6);
    scl_out <= #SCL_SKEW 1'b1;
    w(8);
    sda_pull_out = 1'b0;
    w(8);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack_me, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(~ack_me, r);
  endtask
endmodule

// file: verif/two_wire_wiper_control_bench.sv
/*
 * self-checking bench for the wiper control core, driven through the master model.
 * assumes the core's hand-over timing and a shortened nonvolatile write cycle.
 */
`include "twwc_defs.svh"

module two_wire_wiper_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NV_CYC = 400;
  logic clock_in, resetn_in, scl, sda_pull, sda_out, sda_oe, wp_n, busy, foreign, oe_seen;
  logic [1:0] strap;
  logic [9:0] wiper, v, rv;
  logic [1023:0] tap;
  logic [19:0] lfsr_reg;
  logic [9:0] slot_model [4];
  logic ok;
  wire sda_line;
  int fails = 0;
  int comparisons = 0;

  ////////////////////////////////////////////////////////////////////////////
  // wired-and data line with pull-up
  assign sda_line = ((sda_oe & ~sda_out) | sda_pull) ? 1'b0 : 1'b1;

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  twwc_core #(.NV_WRITE_CYCLES(NV_CYC)) dut (
    .clock_in(clock_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .address_strap_pins_in(strap),
    .write_protect_n_in(wp_n), .wiper_position_out(wiper), .tap_select_out(tap),
    .busy_out(busy)
  );

  twwc_master_model m (
    .clock_in(clock_in), .sda_in(sda_line), .scl_out(scl), .sda_pull_out(sda_pull)
  );

  // remembers any core pull (sda_oe) while another device is addressed
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      oe_seen <= 1'b0;
    end else if (foreign && sda_oe) begin
      oe_seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] lfsr_next(input logic [19:0] s);
    return {s[18:0], s[19] ^ s[16]};
  endfunction

  task automatic rnd(output logic [9:0] r);
    lfsr_reg = lfsr_next(lfsr_reg);
    r = lfsr_reg[9:0];
  endtask

  task automatic check(input bit good, input string msg);
    comparisons++;
    if (!good) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one full transaction; 10-bit values go low byte first
  task automatic xact(input logic [1:0] st, input logic [3:0] oprw, input logic [1:0] slot,
                      input logic [9:0] val, output logic [9:0] rd, output logic good);
    logic a0, a1, a2, a3;
    logic [7:0] lo, hi;
    a2 = 1'b1;
    a3 = 1'b1;
    rd = 10'h000;
    m.start();
    m.wr_byte({`TWWC_TYPE_CODE, st, oprw[0]}, a0);
    m.wr_byte({oprw[3:1], 1'b0, slot, 2'b00}, a1);
    if (oprw == `TWWC_OP_WR_WIPER || oprw == `TWWC_OP_WR_SLOT) begin
      m.wr_byte(val[7:0], a2);
      m.wr_byte({6'h00, val[9:8]}, a3);
    end else if (oprw == `TWWC_OP_RD_WIPER || oprw == `TWWC_OP_RD_SLOT) begin
      m.rd_byte(1'b1, lo);
      m.rd_byte(1'b0, hi);
      rd = {hi[1:0], lo};
    end
    m.stop();
    good = a0 & a1 & a2 & a3;
    m.w(6);
  endtask

  task automatic check_wiper(input logic [9:0] e);
    check(wiper === e, "wiper value");
    check(tap === (1024'h1 << e), "tap select");
  endtask

  // poll with the address until acknowledged; the first poll must be refused
  task automatic poll();
    logic a;
    for (int i = 0; i < 40; i++) begin
      m.start();
      m.wr_byte({`TWWC_TYPE_CODE, strap, 1'b0}, a);
      m.stop();
      if (i == 0) check(!a, "ack while busy");
      if (a) break;
    end
    check(a && busy === 1'b0, "write cycle end");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clock_in);
    check(1'b0, "timeout");
    wrap_up();
  end

  initial begin
    resetn_in = 1'b0;
    strap = 2'h0;
    wp_n = 1'b1;
    foreign = 1'b0;
    lfsr_reg = 20'h142a0;
    repeat (4) @(negedge clock_in);
    resetn_in = 1'b1;
    repeat (10) @(negedge clock_in);
    check_wiper(`TWWC_SLOT_RESET);
    for (int k = 0; k < 4; k++) slot_model[k] = `TWWC_SLOT_RESET;
    rnd(v);
    strap = v[1:0];
    for (int i = 0; i < 3; i++) begin
      rnd(v);
      if (i == 0) v = 10'h3ff;
      xact(strap, `TWWC_OP_WR_WIPER, 2'h0, v, rv, ok);
      check(ok, "write ack");
      check_wiper(v);
      xact(strap, `TWWC_OP_RD_WIPER, 2'h0, 10'h000, rv, ok);
      check(rv === v, "wiper read");
    end
    foreign = 1'b1;
    xact(strap ^ 2'h1, `TWWC_OP_WR_WIPER, 2'h0, ~v, rv, ok);
    foreign = 1'b0;
    check(!ok, "foreign ack");
    check(oe_seen === 1'b0, "line pulled");
    check_wiper(v);
    // opcode 100 with a write bit is not a defined command: the command byte gets no ack
    xact(strap, 4'h8, 2'h0, 10'h000, rv, ok);
    check(!ok, "undefined opcode acked");
    check_wiper(v);
    for (int s = 0; s < 4; s++) begin
      rnd(v);
      xact(strap, `TWWC_OP_WR_SLOT, s[1:0], v, rv, ok);
      check(ok && busy === 1'b1, "slot write");
      poll();
      slot_model[s] = v;
      wp_n = 1'b0;
      xact(strap, `TWWC_OP_WR_SLOT, s[1:0], ~v, rv, ok);
      check(busy === 1'b0, "busy under protect");
      wp_n = 1'b1;
      xact(strap, `TWWC_OP_RD_SLOT, s[1:0], 10'h000, rv, ok);
      check(rv === slot_model[s], "slot read");
    end
    xact(strap, `TWWC_OP_XFR_S2W, 2'h3, 10'h000, rv, ok);
    check_wiper(slot_model[3]);
    rnd(v);
    xact(strap, `TWWC_OP_WR_WIPER, 2'h0, v, rv, ok);
    xact(strap, `TWWC_OP_XFR_W2S, 2'h1, 10'h000, rv, ok);
    check(busy === 1'b1, "transfer busy");
    poll();
    xact(strap, `TWWC_OP_RD_SLOT, 2'h1, 10'h000, rv, ok);
    check(rv === v, "transferred slot");
    wrap_up();
  end
endmodule
